// *** core/radio_pkt_core.sv ***
// Purpose: Radio packet engine: RX FIFO, overflow, TX, lock detect
// Assumes: APB slave, single clock, bytes arrive as rx_byte_valid_i pulses
// Notes:   Summary of operation below
`timescale 1ns/10ps
module radio_pkt_core
  import radio_pkt_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        rx_byte_valid_i,
  input  wire logic [7:0]  rx_byte_i,
  input  wire logic        rx_pkt_end_i,
  input  wire logic [7:0]  rx_rssi_i,
  input  wire logic        rx_crc_ok_i,
  input  wire logic        synth_lock_i,
  input  wire logic [7:0]  synth_cal_i,
  output logic             tx_bit_o,
  output logic             tx_active_o,
  output logic             general_output_pin_o,
  output logic             irq_o
);
  logic [7:0]   fifo_mem [FIFO_DEPTH];
  logic [5:0]   wr_ptr_r;
  logic [5:0]   rd_ptr_r;
  logic [6:0]   count_r;
  logic [7:0]   prefetch_r;
  logic         prefetch_vld_r;
  radio_state_t state_r;
  logic [7:0]   pkt_low_r;
  logic [7:0]   pkt_high_r;
  logic [7:0]   pkt_len_r;
  logic [5:0]   pin_cfg_r;
  logic [7:0]   vco_test_r;
  logic [7:0]   tx_data_r;
  logic [7:0]   tx_cnt_r;
  logic [1:0]   stat_left_r;
  logic [7:0]   stat_byte;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] irq_evt;
  logic         lock_d_r;
  logic         wr_acc;
  logic         rd_acc;
  logic         strobe_idle;
  logic         strobe_flush;
  logic         strobe_rx;
  logic         strobe_tx;
  logic         strobe_sleep;
  logic         rx_push;
  logic [7:0]   rx_push_data;
  logic         fifo_pop;
  logic         host_rx_read;
  logic         overflow_hit;
  logic         fetch;
  logic         byte_done;
  logic         tx_last;
  logic         pkt_handling;

  // Register decode helper
  function automatic logic hit(input logic [11:0] off);
    hit = psel_i && penable_i && (paddr_i == off);
  endfunction

  assign wr_acc       = psel_i && penable_i && pwrite_i;
  assign rd_acc       = psel_i && penable_i && !pwrite_i;
  assign pready_o     = 1'b1;  // Zero wait states
  assign strobe_idle  = wr_acc && hit(OFF_CTRL) && pwdata_i[CTRL_IDLE];
  assign strobe_flush = wr_acc && hit(OFF_CTRL) && pwdata_i[CTRL_FLUSH];
  assign strobe_rx    = wr_acc && hit(OFF_CTRL) && pwdata_i[CTRL_RX];
  assign strobe_tx    = wr_acc && hit(OFF_CTRL) && pwdata_i[CTRL_TX];
  assign strobe_sleep = wr_acc && hit(OFF_CTRL) && pwdata_i[CTRL_SLEEP];
  assign host_rx_read = rd_acc && hit(OFF_RX_DATA);
  assign pkt_handling = pkt_low_r[PKT_HANDLING_BIT];

  // status bytes appended after payload, RSSI then CRC flag
  assign stat_byte    = (stat_left_r == 2'd2) ? rx_rssi_i : {rx_crc_ok_i, 7'h00};
  assign rx_push      = (state_r == ST_RX) && (rx_byte_valid_i || stat_left_r != 2'd0);
  assign rx_push_data = (stat_left_r != 2'd0) ? stat_byte : rx_byte_i;

  // FIFO and pre-fetch both full plus one more byte
  // independent of append and CRC settings
  assign overflow_hit = rx_push && prefetch_vld_r && (count_r == FIFO_FULL);

  // Pre-fetch reloads from FIFO when empty or being read
  assign fifo_pop = (count_r != 7'h00) && (!prefetch_vld_r || host_rx_read);

  // Status byte sequencer
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      stat_left_r <= 2'd0;
    else if (state_r != ST_RX)
      stat_left_r <= 2'd0;
    else if (stat_left_r != 2'd0)
      stat_left_r <= stat_left_r - 2'd1;
    else if (rx_pkt_end_i && pkt_high_r[PKT_APPEND_BIT])
      stat_left_r <= 2'(STATUS_BYTES);
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rx_push && !(count_r == FIFO_FULL))
      fifo_mem[wr_ptr_r] <= rx_push_data;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr_r       <= 6'h00;
      rd_ptr_r       <= 6'h00;
      count_r        <= 7'h00;
      prefetch_r     <= 8'h00;
      prefetch_vld_r <= 1'b0;
    end
    else if (strobe_flush && (state_r != ST_RX) && (state_r != ST_TX))
    begin
      wr_ptr_r       <= 6'h00;
      rd_ptr_r       <= 6'h00;
      count_r        <= 7'h00;
      prefetch_vld_r <= 1'b0;
    end
    else
    begin
      if (rx_push && !(count_r == FIFO_FULL))
        wr_ptr_r <= wr_ptr_r + 6'h01;
      if (fifo_pop)
      begin
        prefetch_r <= fifo_mem[rd_ptr_r];
        rd_ptr_r   <= rd_ptr_r + 6'h01;
      end
      if (fifo_pop)
        prefetch_vld_r <= 1'b1;
      else if (host_rx_read)
        prefetch_vld_r <= 1'b0;
      count_r <= count_r + 7'((rx_push && !(count_r == FIFO_FULL)) ? 1 : 0) - 7'(fifo_pop ? 1 : 0);
    end
  end

  // Radio state machine
  // TX leaves after last byte in packet mode
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_r <= ST_IDLE;
    else if (strobe_idle || strobe_sleep)
      state_r <= ST_IDLE;
    else
    begin
      case (state_r)
        ST_IDLE: if (strobe_rx) state_r <= ST_RX; else if (strobe_tx) state_r <= ST_TX;
        ST_RX:   if (overflow_hit) state_r <= ST_OVF;
        ST_TX:   if (tx_last) state_r <= ST_IDLE;
        ST_OVF:  state_r <= ST_OVF;  // held until an idle or sleep strobe
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  assign tx_last     = pkt_handling && byte_done && (tx_cnt_r == 8'h01);
  assign tx_active_o = (state_r == ST_TX);

  // Packet byte countdown for TX
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      tx_cnt_r <= 8'h00;
    else if (strobe_tx && (state_r == ST_IDLE))
      tx_cnt_r <= pkt_len_r;
    else if (byte_done && (tx_cnt_r != 8'h00))
      tx_cnt_r <= tx_cnt_r - 8'h01;
  end

  // Serialiser; leaving TX any other way is an abort
  tx_byte_shifter u_shift (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .run_i       (state_r == ST_TX),
    .abort_i     (strobe_idle || strobe_sleep),
    .byte_i      (tx_data_r),
    .fetch_o     (fetch),
    .byte_done_o (byte_done),
    .bit_o       (tx_bit_o)
  );

  // Configuration registers
  // VCO test setting lost on sleep
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pkt_low_r  <= 8'h00;
      pkt_high_r <= 8'h00;
      pkt_len_r  <= PKT_LEN_RST;
      pin_cfg_r  <= PIN_CFG_RST;
      vco_test_r <= 8'h00;
      tx_data_r  <= 8'h00;
    end
    else
    begin
      if (wr_acc && hit(OFF_PKT_LOW))  pkt_low_r  <= pwdata_i[7:0];
      if (wr_acc && hit(OFF_PKT_HIGH)) pkt_high_r <= pwdata_i[7:0];
      if (wr_acc && hit(OFF_PKT_LEN))  pkt_len_r  <= pwdata_i[7:0];
      if (wr_acc && hit(OFF_PIN_CFG))  pin_cfg_r  <= pwdata_i[5:0];
      if (wr_acc && hit(OFF_TX_DATA))  tx_data_r  <= pwdata_i[7:0];
      if (strobe_sleep)
        vco_test_r <= 8'h00;
      else if (wr_acc && hit(OFF_VCO_TEST))
        vco_test_r <= pwdata_i[7:0];
    end
  end

  // overflow function drops pin in overflow
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      general_output_pin_o <= 1'b0;
      lock_d_r             <= 1'b0;
    end
    else
    begin
      lock_d_r <= synth_lock_i;
      case (pin_cfg_r)
        PIN_FN_RX_OVF: general_output_pin_o <= (state_r == ST_RX) && (count_r != 7'h00);
        PIN_FN_LOCK:   general_output_pin_o <= synth_lock_i;
        default:       general_output_pin_o <= 1'b0;
      endcase
    end
  end

  // Sticky interrupt flags; set beats write-one clear
  assign irq_evt[IRQ_RX_BYTE] = rx_push && (state_r == ST_RX);
  assign irq_evt[IRQ_RX_OVF]  = overflow_hit;
  assign irq_evt[IRQ_TX_DONE] = tx_last;
  assign irq_evt[IRQ_LOCK]    = synth_lock_i && !lock_d_r;
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
    end
    else
    begin
      irq_stat_r <= (irq_stat_r & ~((wr_acc && hit(OFF_IRQ_STAT)) ? pwdata_i[IRQ_W-1:0] : '0)) | irq_evt;
      if (wr_acc && hit(OFF_IRQ_MASK))
        irq_mask_r <= pwdata_i[IRQ_W-1:0];
    end
  end
  assign irq_o = |(irq_stat_r & irq_mask_r);

  // Read mux; unmapped reads zero with error
  // unlocked calibration forced to 0x3F, locked never 0x3F
  always_comb
  begin
    prdata_o  = 32'h0000_0000;
    pslverr_o = 1'b0;
    case (paddr_i)
      OFF_CTRL:      prdata_o = 32'h0000_0000;
      OFF_PKT_LOW:   prdata_o = {24'h0, pkt_low_r};
      OFF_PKT_HIGH:  prdata_o = {24'h0, pkt_high_r};
      OFF_PKT_LEN:   prdata_o = {24'h0, pkt_len_r};
      OFF_PIN_CFG:   prdata_o = {26'h0, pin_cfg_r};
      // Bit 2 is spare, so fetch lands on bit 10
      OFF_STATUS:    prdata_o = {21'h0, fetch, synth_lock_i, prefetch_vld_r, ((count_r == 7'h00) ? 5'h00 : 5'h01),
                                 1'b0, state_r};
      OFF_RX_DATA:   prdata_o = {24'h0, prefetch_r};
      OFF_TX_DATA:   prdata_o = {24'h0, tx_data_r};
      OFF_SYNTH_CAL: prdata_o = {24'h0, !synth_lock_i ? CAL_UNLOCKED
                                 : (synth_cal_i == CAL_UNLOCKED ? 8'h3E : synth_cal_i)};
      OFF_VCO_TEST:  prdata_o = {24'h0, vco_test_r};
      OFF_IRQ_STAT:  prdata_o = {28'h0, irq_stat_r};
      OFF_IRQ_MASK:  prdata_o = {28'h0, irq_mask_r};
      default:       pslverr_o = psel_i && penable_i;
    endcase
  end
endmodule

// *** core/radio_pkt_pkg.sv ***
// Purpose: Shared constants for the radio packet block
// Assumes: APB, 32-bit data, one word per register
// Notes:   Offsets are byte addresses
package radio_pkt_pkg;
  localparam logic [11:0] OFF_CTRL      = 12'h000;
  localparam logic [11:0] OFF_PKT_LOW   = 12'h004;
  localparam logic [11:0] OFF_PKT_HIGH  = 12'h008;
  localparam logic [11:0] OFF_PKT_LEN   = 12'h00C;
  localparam logic [11:0] OFF_PIN_CFG   = 12'h010;
  localparam logic [11:0] OFF_STATUS    = 12'h014;
  localparam logic [11:0] OFF_RX_DATA   = 12'h018;
  localparam logic [11:0] OFF_TX_DATA   = 12'h01C;
  localparam logic [11:0] OFF_SYNTH_CAL = 12'h020;
  localparam logic [11:0] OFF_VCO_TEST  = 12'h024;
  localparam logic [11:0] OFF_IRQ_STAT  = 12'h028;
  localparam logic [11:0] OFF_IRQ_MASK  = 12'h02C;
  // Control strobe bits (write one)
  localparam int CTRL_IDLE  = 0;
  localparam int CTRL_FLUSH = 1;
  localparam int CTRL_RX    = 2;
  localparam int CTRL_TX    = 3;
  localparam int CTRL_SLEEP = 4;
  // Packet control fields
  localparam int PKT_CRC_EN_BIT   = 2;
  localparam int PKT_VAR_LEN_BIT  = 0;
  localparam int PKT_APPEND_BIT   = 2;
  localparam int PKT_HANDLING_BIT = 3;
  // Pin function codes
  localparam logic [5:0] PIN_FN_RX_OVF = 6'h06;
  localparam logic [5:0] PIN_FN_LOCK   = 6'h0A;
  localparam logic [5:0] PIN_CFG_RST   = 6'h00;
  // FIFO sizing
  localparam int          FIFO_DEPTH   = 64;
  localparam logic [6:0]  FIFO_FULL    = 7'h40;
  localparam int          STATUS_BYTES = 2;
  localparam logic [7:0]  CAL_UNLOCKED = 8'h3F;
  localparam logic [7:0]  PKT_LEN_RST  = 8'hFF;
  // Modulator bit time in clock cycles
  localparam int          BIT_CYCLES   = 8;
  localparam logic [2:0]  HALF_BIT_IDX = 3'h4;
  // Interrupt bits
  localparam int IRQ_RX_BYTE = 0;
  localparam int IRQ_RX_OVF  = 1;
  localparam int IRQ_TX_DONE = 2;
  localparam int IRQ_LOCK    = 3;
  localparam int IRQ_W       = 4;
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_RX   = 2'b01,
    ST_TX   = 2'b10,
    ST_OVF  = 2'b11
  } radio_state_t;
endpackage

// *** core/tx_byte_shifter.sv ***
// Purpose: Modulator byte serialiser with fetch flag
// Assumes: One bit every BIT_CYCLES clocks
// Notes:   Abort clears the fetch flag at once
`timescale 1ns/10ps
module tx_byte_shifter
  import radio_pkt_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       run_i,
  input  wire logic       abort_i,
  input  wire logic [7:0] byte_i,
  output logic            fetch_o,
  output logic            byte_done_o,
  output logic            bit_o
);
  logic [7:0] shift_r;
  logic [2:0] bit_idx_r;
  logic [7:0] tick_r;
  logic       busy_r;
  logic       tick_end;

  assign tick_end    = busy_r && (tick_r == 8'(BIT_CYCLES - 1));
  assign byte_done_o = tick_end && (bit_idx_r == 3'h7);

  // Bit timing and shifting
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      shift_r   <= 8'h00;
      bit_idx_r <= 3'h0;
      tick_r    <= 8'h00;
      busy_r    <= 1'b0;
      bit_o     <= 1'b0;
    end
    else if (abort_i || !run_i)
    begin
      busy_r    <= 1'b0;
      bit_idx_r <= 3'h0;
      tick_r    <= 8'h00;
    end
    else if (!busy_r || byte_done_o)
    begin
      shift_r   <= {byte_i[6:0], 1'b0};
      bit_o     <= byte_i[7];
      bit_idx_r <= 3'h0;
      tick_r    <= 8'h00;
      busy_r    <= 1'b1;
    end
    else if (tick_end)
    begin
      bit_o     <= shift_r[7];
      shift_r   <= {shift_r[6:0], 1'b0};
      bit_idx_r <= bit_idx_r + 3'h1;
      tick_r    <= 8'h00;
    end
    else
    begin
      tick_r <= tick_r + 8'h01;
    end
  end

  // abort clears fetch, so no repeat
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      fetch_o <= 1'b0;
    else if (abort_i || !run_i)
      fetch_o <= 1'b0;
    else if (!busy_r || byte_done_o)
      fetch_o <= 1'b1;
    else if (tick_end && (bit_idx_r == HALF_BIT_IDX - 3'h1))
      fetch_o <= 1'b0;
  end
endmodule

// *** tb/host_apb_model.sv ***
// Purpose: Host processor model speaking APB
// Assumes: Signals change only just after a rising edge
// Notes:   Released address and data are inverted, never stale
`timescale 1ns/10ps
module host_apb_model
(
  input  wire logic        sys_clk_i,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [11:0]      paddr_o,
  output logic [31:0]      pwdata_o
);
  // Idle bus at time zero
  initial
  begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = 12'h000;
    pwdata_o  = 32'h0;
  end
  // Setup, then access held until ready is sampled high
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge sys_clk_i);
    psel_o    <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o  <= wr;
    paddr_o   <= a;
    pwdata_o  <= d;
    @(posedge sys_clk_i);
    penable_o <= 1'b1;
    // Only the bench watchdog ends a wait
    do
    begin
      @(posedge sys_clk_i);
    end
    while (!pready_i);
    rd = prdata_i;
    err = pslverr_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    paddr_o   <= ~a;
    pwdata_o  <= ~d;
  endtask
endmodule

// *** tb/radio_pkt_asserts.sv ***
// Purpose: Port-level checks for radio_pkt_core
// Assumes: Pin function shadowed from APB write commits
// Notes:   One clock domain, reset disables all checks
`timescale 1ns/10ps
module radio_pkt_asserts
  import radio_pkt_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        synth_lock_i,
  input wire logic        tx_active_o,
  input wire logic        general_output_pin_o
);
  logic [5:0] pin_cfg_r;
  logic       acc;
  logic       cal_rd;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Access phase and calibration read decode
  assign acc    = psel_i && penable_i;
  assign cal_rd = acc && !pwrite_i && paddr_i == OFF_SYNTH_CAL;
  // Shadow of pin function; commits on the same edge as the design
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
    if (!rst_n_i)
      pin_cfg_r <= PIN_CFG_RST;
    else if (acc && pwrite_i && paddr_i == OFF_PIN_CFG)
      pin_cfg_r <= pwdata_i[5:0];
  zero_wait_a:
    assert property (psel_i |-> pready_o)
    else $error("ready low during transfer");
  unmapped_err_a:
    assert property (acc && paddr_i > OFF_IRQ_MASK |-> pslverr_o)
    else $error("no error on unmapped address");
  mapped_ok_a:
    assert property (acc && paddr_i <= OFF_IRQ_MASK && paddr_i[1:0] == 2'h0 |-> !pslverr_o)
    else $error("error on mapped address");
  cal_locked_a:
    assert property (cal_rd && synth_lock_i && $past(synth_lock_i) |-> prdata_o[7:0] != CAL_UNLOCKED)
    else $error("calibration reads unlocked value while locked");
  cal_unlocked_a:
    assert property (cal_rd && !synth_lock_i && !$past(synth_lock_i) |-> prdata_o[7:0] == CAL_UNLOCKED)
    else $error("calibration value wrong while unlocked");
  pin_lock_a:
    assert property ($past(pin_cfg_r) == PIN_FN_LOCK |-> general_output_pin_o == $past(synth_lock_i))
    else $error("pin does not follow lock");
  lock_rise_a:
    assert property ($past(pin_cfg_r) == PIN_FN_LOCK && pin_cfg_r == PIN_FN_LOCK && $rose(synth_lock_i)
                     |=> $rose(general_output_pin_o))
    else $error("lock rise not shown on pin");
  pin_quiet_a:
    assert property ($past(pin_cfg_r) != PIN_FN_LOCK && $past(pin_cfg_r) != PIN_FN_RX_OVF
                     |-> !general_output_pin_o)
    else $error("pin driven with no function");
  tx_ends_a:
    assert property ($rose(tx_active_o) |-> ##[1:1000] !tx_active_o)
    else $error("transmit never ends");
endmodule

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench for radio_pkt_core
// Assumes: Host model drives APB, bench drives the radio side
// Notes:   Seeded random bytes; transmit frames kept short
`timescale 1ns/10ps
module tb_top;
  import radio_pkt_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic        rxv, rx_end, crc_ok, lock, tx_bit, tx_act, pin, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  rx_byte, rssi, cal, txd;
  int          errors, num_checks, seed, n;
  logic [7:0]  q [$];
  host_apb_model u_host (.sys_clk_i(clk), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr),
    .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
  radio_pkt_core i_dut (.sys_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .rx_byte_valid_i(rxv), .rx_byte_i(rx_byte), .rx_pkt_end_i(rx_end),
    .rx_rssi_i(rssi), .rx_crc_ok_i(crc_ok), .synth_lock_i(lock), .synth_cal_i(cal),
    .tx_bit_o(tx_bit), .tx_active_o(tx_act), .general_output_pin_o(pin), .irq_o(irq));
  // Free-running clock
  always #5 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, rd, err);
    #1;
  endtask
  task automatic rdk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    u_host.xfer(1'b0, a, 32'h0, rd, err);
    chk(rd & m, e);
  endtask
  task automatic push(input logic [7:0] b);
    @(posedge clk);
    rxv     <= 1'b1;
    rx_byte <= b;
    @(posedge clk);
    rxv     <= 1'b0;
    rx_byte <= ~b;
  endtask
  task automatic complete_run;
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog: whole run needs a few thousand cycles
  initial
  begin
    #500000;
    errors++;
    complete_run;
  end
  initial
  begin
    {clk, rst_n, rxv, rx_end, crc_ok, lock} = 6'h00;
    {rx_byte, rssi, cal} = 24'h0;
    errors = 0;
    num_checks = 0;
    seed = 32'hD45D;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rdk(OFF_PKT_LEN, 32'hFF, {24'h0, PKT_LEN_RST});
    rdk(OFF_PIN_CFG, 32'h3F, 32'h0);
    u_host.xfer(1'b0, 12'h030, 32'h0, rd, err);
    chk({31'h0, err}, 32'h1);
    wr(OFF_IRQ_MASK, 32'h1 << IRQ_RX_OVF);
    wr(OFF_PIN_CFG, {26'h0, PIN_FN_RX_OVF});
    // Overflow for every append and CRC combination
    for (int i = 0; i < 4; i++)
    begin
      wr(OFF_PKT_LOW, {31'h0, i[0]} << PKT_CRC_EN_BIT);
      wr(OFF_PKT_HIGH, {31'h0, i[1]} << PKT_APPEND_BIT);
      wr(OFF_CTRL, 32'h1 << CTRL_RX);
      q.delete();
      for (int k = 0; k < FIFO_DEPTH + 1; k++)
      begin
        q.push_back(8'($random(seed)));
        push(q[k]);
      end
      rdk(OFF_STATUS, 32'h3, {30'h0, ST_RX});
      chk({31'h0, pin}, 32'h1);
      push(8'($random(seed)));
      rdk(OFF_STATUS, 32'h3, {30'h0, ST_OVF});
      chk({31'h0, pin}, 32'h0);
      chk({31'h0, irq}, 32'h1);
      rdk(OFF_RX_DATA, 32'hFF, {24'h0, q[0]});
      // Room made first, so a wrongly accepted byte would land
      push(8'h5A);
      for (int k = 1; k < FIFO_DEPTH; k++)
        rdk(OFF_RX_DATA, 32'hFF, {24'h0, q[k]});
      rdk(OFF_STATUS, 32'hF8, 32'h0);
      wr(OFF_IRQ_MASK, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(OFF_IRQ_MASK, 32'h1 << IRQ_RX_OVF);
      wr(OFF_IRQ_STAT, 32'hF);
      chk({31'h0, irq}, 32'h0);
      wr(OFF_CTRL, 32'h1 << CTRL_IDLE);
      wr(OFF_CTRL, 32'h1 << CTRL_FLUSH);
      rdk(OFF_STATUS, 32'h1FB, 32'h0);
    end
    // short packet, read long before the FIFO fills
    wr(OFF_PKT_HIGH, 32'h1 << PKT_APPEND_BIT);
    wr(OFF_PKT_LEN, 32'h3E);
    wr(OFF_CTRL, 32'h1 << CTRL_RX);
    @(posedge clk);
    rssi   <= 8'($random(seed));
    crc_ok <= 1'($random(seed));
    for (int k = 0; k < 3; k++)
      push(q[k]);
    @(posedge clk);
    rx_end <= 1'b1;
    @(posedge clk);
    rx_end <= 1'b0;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 3; k++)
      rdk(OFF_RX_DATA, 32'hFF, {24'h0, q[k]});
    rdk(OFF_RX_DATA, 32'hFF, {24'h0, rssi});
    rdk(OFF_RX_DATA, 32'hFF, {24'h0, crc_ok, 7'h0});
    wr(OFF_CTRL, 32'h1 << CTRL_IDLE);
    // Packet handling on: two-byte frame ends by itself
    wr(OFF_PKT_LOW, 32'h1 << PKT_HANDLING_BIT);
    wr(OFF_PKT_LEN, 32'h2);
    txd = 8'($random(seed));
    wr(OFF_TX_DATA, {24'h0, txd});
    wr(OFF_CTRL, 32'h1 << CTRL_TX);
    chk({31'h0, tx_act}, 32'h1);
    n = 0;
    // Serial bits sampled mid-bit, MSB first, byte resent
    while (tx_act === 1'b1 && n < 400)
    begin
      @(posedge clk);
      n++;
      if (n % BIT_CYCLES == BIT_CYCLES / 2 + 1 && n < 16 * BIT_CYCLES)
        chk({31'h0, tx_bit}, {31'h0, txd[7 - ((n / BIT_CYCLES) % 8)]});
    end
    chk({31'h0, n > 16 * BIT_CYCLES - 4 && n <= 16 * BIT_CYCLES + 4}, 32'h1);
    // Abort in the first half of a byte
    wr(OFF_PKT_LOW, 32'h0);
    wr(OFF_CTRL, 32'h1 << CTRL_TX);
    repeat (2 * BIT_CYCLES) @(posedge clk);
    rdk(OFF_STATUS, 32'h400, 32'h400);
    wr(OFF_CTRL, 32'h1 << CTRL_IDLE);
    rdk(OFF_STATUS, 32'h403, 32'h0);
    wr(OFF_CTRL, 32'h1 << CTRL_TX);
    repeat (5 * BIT_CYCLES) @(posedge clk);
    rdk(OFF_STATUS, 32'h400, 32'h0);
    // idle only after twelve dummy bits
    repeat (7 * BIT_CYCLES) @(posedge clk);
    wr(OFF_CTRL, 32'h1 << CTRL_IDLE);
    chk({31'h0, tx_act}, 32'h0);
    // Lock detect on the pin
    wr(OFF_PIN_CFG, {26'h0, PIN_FN_LOCK});
    wr(OFF_IRQ_MASK, 32'h1 << IRQ_LOCK);
    for (int k = 0; k < 12; k++)
    begin
      @(posedge clk);
      lock <= 1'($random(seed));
      repeat (2) @(posedge clk);
      chk({31'h0, pin}, {31'h0, lock});
    end
    @(posedge clk);
    lock <= 1'b0;
    cal  <= CAL_UNLOCKED;
    rdk(OFF_SYNTH_CAL, 32'hFF, {24'h0, CAL_UNLOCKED});
    wr(OFF_IRQ_STAT, 32'hF);
    @(posedge clk);
    lock <= 1'b1;
    rdk(OFF_SYNTH_CAL, 32'hFF, 32'h3E);
    chk({31'h0, irq}, 32'h1);
    wr(OFF_IRQ_MASK, 32'h0);
    wr(OFF_VCO_TEST, 32'hA5);
    wr(OFF_CTRL, 32'h1 << CTRL_SLEEP);
    rdk(OFF_VCO_TEST, 32'hFF, 32'h0);
    wr(OFF_VCO_TEST, 32'hA5);
    rdk(OFF_VCO_TEST, 32'hFF, 32'hA5);
    complete_run;
  end
endmodule
bind radio_pkt_core radio_pkt_asserts u_chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .synth_lock_i(synth_lock_i),
  .tx_active_o(tx_active_o), .general_output_pin_o(general_output_pin_o));
